/* File: alu_ext_pkg.sv */
// Constants and enumerations shared by the extended shift/subtract datapath
package alu_ext_pkg;
   localparam int ADDR_W   = 20;
   localparam int WORD_MSB = 15;
   localparam int BYTE_MSB = 7;
   localparam int ADDR_MSB = 19;
   localparam int CNT_W    = 3;
   localparam logic [2:0] CNT_MIN = 3'h1;
   localparam logic [2:0] CNT_MAX = 3'h4;
   localparam logic [19:0] ONES_A = 20'hFFFFF;
   localparam logic [19:0] ONES_W = 20'h0FFFF;
   localparam logic [19:0] ONES_B = 20'h000FF;
   localparam logic [19:0] ZERO20 = 20'h00000;
   localparam logic [3:0]  ZERO4  = 4'h0;
   localparam logic [2:0]  BE_A   = 3'h7;
   localparam logic [2:0]  BE_W   = 3'h3;
   localparam logic [2:0]  BE_B   = 3'h1;

   // Operand width suffix
   typedef enum logic [1:0] {
      WID_BYTE = 2'h0,
      WID_WORD = 2'h1,
      WID_ADDR = 2'h2
   } width_t;

   // Operation select
   typedef enum logic [2:0] {
      OP_ROTATE_RIGHT_CARRY_EXT      = 3'h0,
      OP_SHIFT_RIGHT_UNSIGNED_EXT    = 3'h1,
      OP_SHIFT_RIGHT_UNSIGNED_MULTI  = 3'h2,
      OP_SUBTRACT_BORROW_EXT         = 3'h3,
      OP_SUBTRACT_EXT                = 3'h4,
      OP_SUBTRACT_WITH_CARRY_EXT     = 3'h5
   } op_t;

   // Sequencer states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_DONE = 2'b10
   } state_t;
endpackage

/* File: width_mask.sv */
// Width mask, sign bit pick and byte-lane enables for the active operand width
`timescale 1ns/1ps
module width_mask (
   input  wire alu_ext_pkg::width_t width,
   input  wire logic [19:0]         value,
   output logic [19:0]              mask,
   output logic                     signBit,
   output logic [2:0]               laneEn
);
   // Select mask, sign position and written byte lanes
   always_comb begin
      case (width)
         alu_ext_pkg::WID_BYTE: begin
            mask    = alu_ext_pkg::ONES_B;
            signBit = value[alu_ext_pkg::BYTE_MSB];
            laneEn  = alu_ext_pkg::BE_B;
         end
         alu_ext_pkg::WID_WORD: begin
            mask    = alu_ext_pkg::ONES_W;
            signBit = value[alu_ext_pkg::WORD_MSB];
            laneEn  = alu_ext_pkg::BE_W;
         end
         default: begin
            mask    = alu_ext_pkg::ONES_A;
            signBit = value[alu_ext_pkg::ADDR_MSB];
            laneEn  = alu_ext_pkg::BE_A;
         end
      endcase
   end
endmodule // width_mask

/* File: right_shifter.sv */
// Right shift by a count of one to four with a selectable fill bit at the top
`timescale 1ns/1ps
module right_shifter (
   input  wire alu_ext_pkg::width_t width,
   input  wire logic [19:0]         operand,
   input  wire logic [2:0]          count,
   input  wire logic                fillBit,
   output logic [19:0]              result,
   output logic                     carryOut
);
   logic [19:0] cur;
   logic [2:0]  idx;
   // One position per step; the fill enters the active sign position
   always_comb begin
      cur      = operand;
      carryOut = 1'b0;
      idx      = 3'h0;
      for (int i = 0; i < 4; i++) begin
         idx = 3'(i + 1);
         if (idx <= count) begin
            carryOut = cur[0];
            cur      = {1'b0, cur[19:1]};
            case (width)
               alu_ext_pkg::WID_BYTE: cur[alu_ext_pkg::BYTE_MSB] = fillBit;
               alu_ext_pkg::WID_WORD: cur[alu_ext_pkg::WORD_MSB] = fillBit;
               default:               cur[alu_ext_pkg::ADDR_MSB] = fillBit;
            endcase
         end
      end
      result = cur;
   end
endmodule // right_shifter

/* File: extended_shift_subtract_alu.sv */
// Extended rotate, unsigned shift and subtract datapath with flag generation
`timescale 1ns/1ps
module extended_shift_subtract_alu (
   input  wire logic                core_clk,
   input  wire logic                rst_b,
   input  wire logic                start,
   input  wire alu_ext_pkg::op_t    opSel,
   input  wire alu_ext_pkg::width_t width,
   input  wire logic                dstIsReg,
   input  wire logic                dstIsImm,
   input  wire logic                extWordSeen,
   input  wire logic [2:0]          shiftCount,
   input  wire logic [19:0]         srcOperand,
   input  wire logic [19:0]         dstOperand,
   input  wire logic                carryIn,
   input  wire logic                oscillator_off_bit,
   input  wire logic                core_off_bit,
   input  wire logic                global_interrupt_enable,
   output logic                     done_ff,
   output logic                     illegal_ff,
   output logic [19:0]              result_ff,
   output logic                     regWrite_ff,
   output logic                     memWrite_ff,
   output logic [2:0]               memByteEn_ff,
   output logic                     flagN_ff,
   output logic                     flagZ_ff,
   output logic                     flagC_ff,
   output logic                     flagV_ff,
   output logic                     modeOscOff_ff,
   output logic                     modeCoreOff_ff,
   output logic                     modeGie_ff
);

   alu_ext_pkg::state_t state_ff;
   alu_ext_pkg::state_t nxt_state;

   logic [19:0] widthMask;
   logic        dstSign;
   logic        srcSign;
   logic        resSign;
   logic [2:0]  laneEn;
   logic [19:0] dstM;
   logic [19:0] srcM;
   logic [19:0] shRes;
   logic        shCarry;
   logic [2:0]  shCount;
   logic        shFill;
   logic [19:0] addB;
   logic        addCin;
   logic [20:0] sum;
   logic [19:0] sumM;
   logic        sumCarry;
   logic        isShift;
   logic        opLegal;
   logic [19:0] nxt_result;
   logic        nxt_c;
   logic        nxt_v;
   logic        nxt_n;
   logic        nxt_z;

   // Width decode for destination, source and result
   width_mask uDstMask (
      .width   (width),
      .value   (dstOperand),
      .mask    (widthMask),
      .signBit (dstSign),
      .laneEn  (laneEn)
   );

   width_mask uSrcMask (
      .width   (width),
      .value   (srcOperand),
      .mask    (),
      .signBit (srcSign),
      .laneEn  ()
   );

   width_mask uResMask (
      .width   (width),
      .value   (nxt_result),
      .mask    (),
      .signBit (resSign),
      .laneEn  ()
   );

   // Operands cut to the active width; the source is only ever read
   assign dstM = dstOperand & widthMask;
   assign srcM = srcOperand & widthMask;

   // Shift count and fill: single ops shift one, multi shifts n
   always_comb begin
      shCount = 3'h1;
      shFill  = 1'b0;
      case (opSel)
         alu_ext_pkg::OP_ROTATE_RIGHT_CARRY_EXT: begin
            shFill = carryIn;
         end
         alu_ext_pkg::OP_SHIFT_RIGHT_UNSIGNED_MULTI: begin
            shCount = shiftCount;
         end
         default: begin
            shFill = 1'b0;
         end
      endcase
   end

   right_shifter uShift (
      .width    (width),
      .operand  (dstM),
      .count    (shCount),
      .fillBit  (shFill),
      .result   (shRes),
      .carryOut (shCarry)
   );

   // Adder operand: all-ones for borrow, inverted source for subtracts
   always_comb begin
      case (opSel)
         alu_ext_pkg::OP_SUBTRACT_BORROW_EXT: begin
            addB   = widthMask;
            addCin = carryIn;
         end
         alu_ext_pkg::OP_SUBTRACT_WITH_CARRY_EXT: begin
            addB   = ~srcM & widthMask;
            addCin = carryIn;
         end
         default: begin
            addB   = ~srcM & widthMask;
            addCin = 1'b1;
         end
      endcase
   end

   // Active-width add with one spare bit to catch the carry
   assign sum  = {1'b0, dstM} + {1'b0, addB} + {20'h00000, addCin};
   assign sumM = sum[19:0] & widthMask;

   // Carry out of the active-width MSB
   always_comb begin
      case (width)
         alu_ext_pkg::WID_BYTE: sumCarry = sum[alu_ext_pkg::BYTE_MSB + 1];
         alu_ext_pkg::WID_WORD: sumCarry = sum[alu_ext_pkg::WORD_MSB + 1];
         default:               sumCarry = sum[alu_ext_pkg::ADDR_MSB + 1];
      endcase
   end

   // Rotates and shifts take their result from the shifter
   assign isShift = (opSel == alu_ext_pkg::OP_ROTATE_RIGHT_CARRY_EXT) ||
                    (opSel == alu_ext_pkg::OP_SHIFT_RIGHT_UNSIGNED_EXT) ||
                    (opSel == alu_ext_pkg::OP_SHIFT_RIGHT_UNSIGNED_MULTI);

   // Legality of addressing mode, width, count and encoding
   always_comb begin
      case (opSel)
         alu_ext_pkg::OP_ROTATE_RIGHT_CARRY_EXT:
            opLegal = !dstIsImm;
         alu_ext_pkg::OP_SHIFT_RIGHT_UNSIGNED_EXT:
            opLegal = dstIsReg && !dstIsImm;
         alu_ext_pkg::OP_SHIFT_RIGHT_UNSIGNED_MULTI:
            opLegal = dstIsReg && !dstIsImm && !extWordSeen &&
                      (width != alu_ext_pkg::WID_BYTE) &&
                      (shiftCount >= alu_ext_pkg::CNT_MIN) &&
                      (shiftCount <= alu_ext_pkg::CNT_MAX);
         alu_ext_pkg::OP_SUBTRACT_BORROW_EXT,
         alu_ext_pkg::OP_SUBTRACT_EXT,
         alu_ext_pkg::OP_SUBTRACT_WITH_CARRY_EXT:
            opLegal = !dstIsImm;
         default:
            opLegal = 1'b0;
      endcase
   end

   // Result and flag values; narrow register results clear upper bits
   always_comb begin
      if (isShift) begin
         nxt_result = shRes & widthMask;
         nxt_c      = shCarry;
         nxt_v      = 1'b0;
      end else begin
         nxt_result = sumM;
         nxt_c      = sumCarry;
         if (opSel == alu_ext_pkg::OP_SUBTRACT_BORROW_EXT) begin
            // Adding all-ones plus carry can only wrap negative to positive
            nxt_v = dstSign && !resSign;
         end else begin
            nxt_v = (srcSign && !dstSign && resSign) ||
                    (!srcSign && dstSign && !resSign);
         end
      end
      nxt_n = resSign;
   end

   // Zero flag from the cut result; equal operands give zero
   assign nxt_z = (nxt_result == alu_ext_pkg::ZERO20);

   // Sequencer: one done cycle per start, accepted or refused
   always_comb begin
      case (state_ff)
         alu_ext_pkg::ST_IDLE: nxt_state = start ? alu_ext_pkg::ST_DONE : alu_ext_pkg::ST_IDLE;
         alu_ext_pkg::ST_DONE: nxt_state = start ? alu_ext_pkg::ST_DONE : alu_ext_pkg::ST_IDLE;
         default:              nxt_state = alu_ext_pkg::ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         state_ff <= alu_ext_pkg::ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Completion pulse one cycle after every start, refusal pulse one cycle after each refused start
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         done_ff    <= 1'b0;
         illegal_ff <= 1'b0;
      end else begin
         done_ff    <= start;
         illegal_ff <= start && !opLegal;
      end
   end

   // Write strobes; a refused request writes nothing
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         regWrite_ff  <= 1'b0;
         memWrite_ff  <= 1'b0;
         memByteEn_ff <= 3'h0;
      end else begin
         regWrite_ff  <= start && opLegal && dstIsReg;
         memWrite_ff  <= start && opLegal && !dstIsReg;
         memByteEn_ff <= (start && opLegal && !dstIsReg) ? laneEn : 3'h0;
      end
   end

   // Result register; refused requests keep the old value
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         result_ff <= alu_ext_pkg::ZERO20;
      end else if (start && opLegal) begin
         result_ff <= nxt_result;
      end
   end

   // Sign and zero flags, held across refused requests
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         flagN_ff <= 1'b0;
         flagZ_ff <= 1'b0;
      end else if (start && opLegal) begin
         flagN_ff <= nxt_n;
         flagZ_ff <= nxt_z;
      end
   end

   // Carry and overflow flags, held across refused requests
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         flagC_ff <= 1'b0;
         flagV_ff <= 1'b0;
      end else if (start && opLegal) begin
         flagC_ff <= nxt_c;
         flagV_ff <= nxt_v;
      end
   end

   // Mode bits pass through untouched by any operation
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         modeOscOff_ff  <= 1'b0;
         modeCoreOff_ff <= 1'b0;
         modeGie_ff     <= 1'b0;
      end else begin
         modeOscOff_ff  <= oscillator_off_bit;
         modeCoreOff_ff <= core_off_bit;
         modeGie_ff     <= global_interrupt_enable;
      end
   end
endmodule // extended_shift_subtract_alu

/* File: extended_shift_subtract_alu_props.sv */
// Concurrent checks on the ports of the extended shift/subtract datapath
`timescale 1ns/1ps
module extended_shift_subtract_alu_props (
   input wire logic                core_clk,
   input wire logic                rst_b,
   input wire logic                start,
   input wire alu_ext_pkg::op_t    opSel,
   input wire alu_ext_pkg::width_t width,
   input wire logic                dstIsReg,
   input wire logic                dstIsImm,
   input wire logic                extWordSeen,
   input wire logic [2:0]          shiftCount,
   input wire logic                oscillator_off_bit,
   input wire logic                done_ff,
   input wire logic                illegal_ff,
   input wire logic [19:0]         result_ff,
   input wire logic                regWrite_ff,
   input wire logic                memWrite_ff,
   input wire logic [2:0]          memByteEn_ff,
   input wire logic                flagN_ff,
   input wire logic                flagC_ff,
   input wire logic                flagV_ff,
   input wire logic                modeOscOff_ff
);
   alu_ext_pkg::width_t lastWid_ff;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // Width of the request now being answered
   always_ff @(posedge core_clk) begin
      lastWid_ff <= width;
   end
   sequence legalDone;
      done_ff && !illegal_ff;
   endsequence
   sequence reqShift;
      start && opSel <= alu_ext_pkg::OP_SHIFT_RIGHT_UNSIGNED_MULTI;
   endsequence
   sequence reqMulti;
      start && opSel == alu_ext_pkg::OP_SHIFT_RIGHT_UNSIGNED_MULTI;
   endsequence
   done_pulse_a: assert property (start |=> done_ff)
      else $error("no answer one cycle after a request");
   done_cause_a: assert property (done_ff |-> $past(start) && $past(rst_b))
      else $error("answer without a request");
   imm_refuse_a: assert property (start && dstIsImm |=> illegal_ff)
      else $error("immediate destination accepted");
   single_refuse_a: assert property (start && !dstIsReg
      && opSel == alu_ext_pkg::OP_SHIFT_RIGHT_UNSIGNED_EXT |=> illegal_ff)
      else $error("single shift on memory accepted");
   multi_refuse_a: assert property (reqMulti ##0 (extWordSeen || !dstIsReg
      || shiftCount < 3'h1 || shiftCount > 3'h4) |=> illegal_ff)
      else $error("bad multi shift accepted");
   refuse_hold_a: assert property (done_ff && illegal_ff |-> $stable(result_ff)
      && $stable(flagC_ff) && !regWrite_ff && !memWrite_ff)
      else $error("refused request changed state");
   upper_clear_a: assert property (legalDone |-> (result_ff & ~(lastWid_ff ==
      alu_ext_pkg::WID_BYTE ? alu_ext_pkg::ONES_B : lastWid_ff == alu_ext_pkg::WID_WORD
      ? alu_ext_pkg::ONES_W : alu_ext_pkg::ONES_A)) == alu_ext_pkg::ZERO20)
      else $error("bits above active width not cleared");
   sign_flag_a: assert property (legalDone |-> flagN_ff == (lastWid_ff ==
      alu_ext_pkg::WID_BYTE ? result_ff[7] : lastWid_ff == alu_ext_pkg::WID_WORD
      ? result_ff[15] : result_ff[19]))
      else $error("negative flag differs from sign bit");
   shift_ovf_a: assert property (reqShift ##1 legalDone |-> !flagV_ff)
      else $error("overflow set after shift");
   lane_enable_a: assert property (memWrite_ff |-> !regWrite_ff && memByteEn_ff ==
      (lastWid_ff == alu_ext_pkg::WID_BYTE ? alu_ext_pkg::BE_B : lastWid_ff ==
      alu_ext_pkg::WID_WORD ? alu_ext_pkg::BE_W : alu_ext_pkg::BE_A))
      else $error("byte lanes do not match width");
   mode_pass_a: assert property ($past(rst_b) |->
      modeOscOff_ff == $past(oscillator_off_bit))
      else $error("mode bit altered");
endmodule // extended_shift_subtract_alu_props
bind extended_shift_subtract_alu extended_shift_subtract_alu_props u_props (
   .core_clk(core_clk), .rst_b(rst_b), .start(start), .opSel(opSel), .width(width),
   .dstIsReg(dstIsReg), .dstIsImm(dstIsImm), .extWordSeen(extWordSeen),
   .shiftCount(shiftCount), .oscillator_off_bit(oscillator_off_bit), .done_ff(done_ff),
   .illegal_ff(illegal_ff), .result_ff(result_ff), .regWrite_ff(regWrite_ff),
   .memWrite_ff(memWrite_ff), .memByteEn_ff(memByteEn_ff), .flagN_ff(flagN_ff),
   .flagC_ff(flagC_ff), .flagV_ff(flagV_ff), .modeOscOff_ff(modeOscOff_ff));

/* File: operand_store.sv */
// Register and memory word behind the datapath, updated by its write strobes
`timescale 1ns/1ps
module operand_store (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        regWrite,
   input  wire logic        memWrite,
   input  wire logic [2:0]  byteEn,
   input  wire logic [19:0] result,
   output logic      [19:0] regQ_ff,
   output logic      [23:0] memQ_ff
);
   logic [23:0] resultWide;

   // Result padded to the three byte lanes of memory
   assign resultWide = {4'h0, result};
   // Register takes the whole 20-bit result
   always_ff @(posedge core_clk) begin
      if (!rst_b) regQ_ff <= 20'h00000;
      else if (regWrite) regQ_ff <= result;
   end
   // Memory keeps every lane that is not enabled
   always_ff @(posedge core_clk) begin
      if (!rst_b) memQ_ff <= 24'hC3C3C3;
      else if (memWrite) begin
         for (int i = 0; i < 3; i++) begin
            if (byteEn[i]) memQ_ff[8*i +: 8] <= resultWide[8*i +: 8];
         end
      end
   end
endmodule // operand_store

/* File: extended_shift_subtract_alu_tb_top.sv */
// Self-checking bench for the extended shift/subtract datapath
`timescale 1ns/1ps
module extended_shift_subtract_alu_tb_top;
   logic core_clk, rst_b, start, dstIsReg, dstIsImm, extWordSeen, carryIn;
   logic oscillator_off_bit, core_off_bit, global_interrupt_enable;
   alu_ext_pkg::op_t opSel;
   alu_ext_pkg::width_t width;
   logic [2:0] shiftCount, memByteEn_ff;
   logic [19:0] srcOperand, dstOperand, result_ff, regQ_ff;
   logic [23:0] memQ_ff, expF;
   logic done_ff, illegal_ff, regWrite_ff, memWrite_ff, flagN_ff, flagZ_ff, flagC_ff, flagV_ff;
   logic modeOscOff_ff, modeCoreOff_ff, modeGie_ff;
   logic [31:0] seed = 32'hCB5817DD;
   logic [19:0] expReg;
   logic [23:0] expMem;
   int n_fail = 0;
   int tests_run = 0;
   extended_shift_subtract_alu u_dut (.core_clk(core_clk), .rst_b(rst_b), .start(start),
      .opSel(opSel), .width(width), .dstIsReg(dstIsReg), .dstIsImm(dstIsImm),
      .extWordSeen(extWordSeen), .shiftCount(shiftCount), .srcOperand(srcOperand),
      .dstOperand(dstOperand), .carryIn(carryIn), .oscillator_off_bit(oscillator_off_bit),
      .core_off_bit(core_off_bit), .global_interrupt_enable(global_interrupt_enable),
      .done_ff(done_ff), .illegal_ff(illegal_ff), .result_ff(result_ff),
      .regWrite_ff(regWrite_ff), .memWrite_ff(memWrite_ff), .memByteEn_ff(memByteEn_ff),
      .flagN_ff(flagN_ff), .flagZ_ff(flagZ_ff), .flagC_ff(flagC_ff), .flagV_ff(flagV_ff),
      .modeOscOff_ff(modeOscOff_ff), .modeCoreOff_ff(modeCoreOff_ff), .modeGie_ff(modeGie_ff));
   operand_store u_store (.core_clk(core_clk), .rst_b(rst_b), .regWrite(regWrite_ff),
      .memWrite(memWrite_ff), .byteEn(memByteEn_ff), .result(result_ff),
      .regQ_ff(regQ_ff), .memQ_ff(memQ_ff));
   // Xorshift source of repeatable random values
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected {N, Z, C, V, result}
   function automatic logic [23:0] refOp(input logic [2:0] o, input logic [1:0] w,
      input logic [2:0] n, input logic [19:0] s, input logic [19:0] d, input logic c);
      logic [20:0] sum;
      logic [19:0] m, r, dm, sm;
      logic cy, v;
      int b;
      m = (w == 2'h0) ? 20'h000FF : (w == 2'h1) ? 20'h0FFFF : 20'hFFFFF;
      b = (w == 2'h0) ? 7 : (w == 2'h1) ? 15 : 19;
      dm = d & m;
      sm = (o == 3'h3) ? 20'h00000 : s & m;
      v = 1'b0;
      if (o <= 3'h1) begin
         r = (dm >> 1) | (20'({c & (o == 3'h0)}) << b);
         cy = dm[0];
      end else if (o == 3'h2) begin
         r = dm >> n;
         cy = dm[n - 3'h1];
      end else begin
         sum = dm + (~sm & m) + ((o == 3'h4) ? 1'b1 : c);
         r = sum[19:0] & m;
         cy = sum[b + 1];
         v = (dm[b] ^ sm[b]) & (r[b] ^ dm[b]);
      end
      return {r[b], r == 20'h00000, cy, v, r};
   endfunction
   function automatic logic bad(input logic [2:0] o, input logic [1:0] w,
      input logic rg, im, ex, input logic [2:0] n);
      return im || (o == 3'h1 && !rg)
         || (o == 3'h2 && (ex || w == 2'h0 || !rg || n < 3'h1 || n > 3'h4));
   endfunction
   task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One request, its answer and the write-back that follows
   task automatic run(input logic [2:0] o, input logic [1:0] w, input logic rg, im, ex,
      input logic [2:0] n, input logic [19:0] s, d, input logic c);
      logic [31:0] md;
      logic [2:0] be;
      logic il;
      logic [23:0] wr;
      md = rnd();
      il = bad(o, w, rg, im, ex, n);
      be = 3'h0;
      @(negedge core_clk);
      start = 1'b1;
      opSel = alu_ext_pkg::op_t'(o);
      width = alu_ext_pkg::width_t'(w);
      {dstIsReg, dstIsImm, extWordSeen, shiftCount, srcOperand, dstOperand} = {rg, im, ex, n, s, d};
      {carryIn, oscillator_off_bit, core_off_bit, global_interrupt_enable} = {c, md[2:0]};
      @(negedge core_clk);
      start = 1'b0;
      if (!il) expF = refOp(o, w, n, s, d, c);
      wr = {4'h0, expF[19:0]};
      for (int i = 0; i < 3; i++) begin
         if (!il && !rg && i <= w) be[i] = 1'b1;
         if (!il && !rg && i <= w) expMem[8*i +: 8] = wr[8*i +: 8];
      end
      if (!il && rg) expReg = expF[19:0];
      chk("done illegal", {46'h0, 1'b1, il}, {46'h0, done_ff, illegal_ff});
      chk("result flags", {24'h0, expF}, {24'h0, flagN_ff, flagZ_ff, flagC_ff, flagV_ff,
         result_ff});
      chk("writes", {43'h0, !il && rg, !il && !rg, be},
         {43'h0, regWrite_ff, memWrite_ff, memByteEn_ff});
      chk("mode bits", {45'h0, md[2:0]},
         {45'h0, modeOscOff_ff, modeCoreOff_ff, modeGie_ff});
      @(negedge core_clk);
      chk("store", {4'h0, expReg, expMem}, {4'h0, regQ_ff, memQ_ff});
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Free-running core clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   // Watchdog against a hung run
   initial begin
      #20000;
      n_fail++;
      conclude();
   end
   // Reset, corner cases, then random traffic
   initial begin
      logic [31:0] r, a, b;
      {rst_b, start, dstIsReg, dstIsImm, extWordSeen, shiftCount, carryIn} = '0;
      {srcOperand, dstOperand, oscillator_off_bit, core_off_bit, global_interrupt_enable} = '0;
      opSel = alu_ext_pkg::OP_SUBTRACT_EXT;
      width = alu_ext_pkg::WID_WORD;
      {expF, expReg, expMem} = {24'h0, 20'h0, 24'hC3C3C3};
      repeat (6) @(negedge core_clk);
      rst_b = 1'b1;
      run(3'h4, 2'h1, 1, 0, 0, 3'h1, 20'h00003, 20'h00005, 0);
      run(3'h4, 2'h2, 0, 0, 0, 3'h1, 20'hABCDE, 20'hABCDE, 0);
      run(3'h3, 2'h0, 1, 0, 0, 3'h1, 20'h12345, 20'hFFF80, 0);
      run(3'h0, 2'h2, 0, 0, 0, 3'h1, 20'h00000, 20'h00000, 1);
      run(3'h0, 2'h1, 1, 0, 0, 3'h1, 20'h00000, 20'hFFFFF, 0);
      run(3'h1, 2'h0, 1, 0, 0, 3'h1, 20'h00000, 20'hFFFFF, 1);
      run(3'h2, 2'h2, 1, 0, 0, 3'h4, 20'h00000, 20'h8000F, 0);
      run(3'h5, 2'h0, 0, 0, 0, 3'h1, 20'h00001, 20'h00080, 0);
      run(3'h0, 2'h1, 1, 1, 0, 3'h1, 20'h00000, 20'h00001, 0);
      run(3'h1, 2'h1, 0, 0, 0, 3'h1, 20'h00000, 20'h00001, 0);
      for (int k = 0; k < 16; k++) begin
         run(3'h2, 2'h1, 1, 0, k[3], k[2:0], 20'h0, 20'h0FFFF, 1);
      end
      $display("corner cases done");
      repeat (500) begin
         r = rnd();
         a = rnd();
         b = rnd();
         run(r[2:0] % 3'h6, (r[4:3] == 2'h3) ? 2'h2 : r[4:3], r[6:5] != 2'h0,
            r[10:7] == 4'h0, r[12:11] == 2'h0, r[15:13], a[19:0], b[19:0], r[16]);
      end
      $display("random traffic done");
      conclude();
   end
endmodule // extended_shift_subtract_alu_tb_top
